//--- clk_startup_pkg.sv
// package: constants and types for clock source start-up selection
package clk_startup_pkg;

    // source clock pin indices into the edge vector
    localparam int NUM_CLK = 5;
    localparam int CLK_EXT = 0;
    localparam int CLK_RC = 1;
    localparam int CLK_K128 = 2;
    localparam int CLK_LF = 3;
    localparam int CLK_WDOG = 4;

    // source-select fuse encodings
    localparam logic [3:0] SEL_EXT = 4'h0;
    localparam logic [3:0] SEL_RC = 4'h2;
    localparam logic [3:0] SEL_K128 = 4'h3;
    localparam logic [2:0] SEL_LF_HI = 3'h3;
    localparam logic [2:0] SEL_LF_LO = 3'h2;

    // start-up-time fuse encodings
    localparam logic [1:0] SUT_SHORT = 2'h0;
    localparam logic [1:0] SUT_MID = 2'h1;
    localparam logic [1:0] SUT_LONG = 2'h2;
    localparam logic [1:0] SUT_RSVD = 2'h3;

    // source clock cycle counts
    localparam logic [15:0] CK_LF_RESET = 16'h0004;
    localparam logic [15:0] CK_INT_RESET = 16'h000e;
    localparam logic [15:0] CK_WAKE_SHORT = 16'h0006;
    localparam logic [15:0] CK_LF_WAKE_1K = 16'h0400;
    localparam logic [15:0] CK_LF_WAKE_32K = 16'h8000;

    // millisecond delays, timed on the watchdog oscillator
    localparam longint WDOG_HZ = 128000;
    localparam longint US_PER_S = 1000000;
    localparam longint T_4P1MS_US = 4100;
    localparam longint T_4MS_US = 4000;
    localparam longint T_65MS_US = 65000;
    localparam longint T_64MS_US = 64000;
    // least times: round up to whole watchdog ticks
    localparam longint WD_4P1MS = (T_4P1MS_US * WDOG_HZ + US_PER_S - 1) / US_PER_S;
    localparam longint WD_4MS = (T_4MS_US * WDOG_HZ + US_PER_S - 1) / US_PER_S;
    localparam longint WD_65MS = (T_65MS_US * WDOG_HZ + US_PER_S - 1) / US_PER_S;
    localparam longint WD_64MS = (T_64MS_US * WDOG_HZ + US_PER_S - 1) / US_PER_S;

    // register byte offsets
    localparam logic [4:0] OFF_TRIM = 5'h00;
    localparam logic [4:0] OFF_PRESC = 5'h04;
    localparam logic [4:0] OFF_STATUS = 5'h08;
    localparam logic [4:0] OFF_FUSE = 5'h0c;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

    // field positions
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_SRC_LSB = 1;
    localparam int STAT_PHASE_LSB = 3;
    localparam int STAT_BADSEL_BIT = 6;
    localparam int STAT_BADSUT_BIT = 7;
    localparam int FUSE_SEL_LSB = 0;
    localparam int FUSE_SUT_LSB = 4;
    localparam int FUSE_RSTDIS_BIT = 6;
    localparam int FUSE_DIV8_BIT = 7;

    // prescaler reset values
    localparam logic [3:0] PRESC_RESET_DIV8 = 4'h3;
    localparam logic [3:0] PRESC_RESET_DIV1 = 4'h0;

    typedef enum logic [1:0] {SRC_EXT, SRC_RC, SRC_K128, SRC_LF} src_t;
    typedef enum logic [2:0] {
        PH_MS, PH_CK, PH_RUN, PH_SLEEP, PH_WAKE
    } phase_t;

    typedef struct packed {
        logic [3:0] sel;
        logic [1:0] startup_time_fuses;
        logic rstdis;
        logic div8;
    } fuse_t;

    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avmm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avmm_rsp_t;

    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
    } sync_state_t;

    typedef struct packed {
        phase_t phase;
        fuse_t fuse;
        src_t src;
        logic bad_sel;
        logic bad_sut;
        logic [15:0] ms_cnt;
        logic [15:0] ms_tgt;
        logic [15:0] ck_cnt;
        logic [15:0] ck_tgt;
        logic clk_en;
        logic [7:0] trim;
        logic [3:0] presc;
        logic waitreq;
        logic [31:0] rdata;
    } core_state_t;

endpackage : clk_startup_pkg

//--- clk_edge_sync.sv
// two-stage synchroniser with rising-edge detect for one clock pin
module clk_edge_sync (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic async_in,
    output logic rise
);
    import clk_startup_pkg::*;

    sync_state_t s_r;
    sync_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (reset) begin
            // last held high: a pin already high at release is no edge
            s_nxt.meta = async_in;
            s_nxt.stable = s_r.meta;
            s_nxt.last = 1'b1;
        end else begin
            s_nxt.meta = async_in;
            s_nxt.stable = s_r.meta;
            s_nxt.last = s_r.stable;
        end
    end

    always_ff @(posedge core_clk) begin
        s_r <= s_nxt;
    end

    // meta is never looked at here, only the settled stages
    assign rise = s_r.stable & ~s_r.last;

endmodule : clk_edge_sync

//--- clock_source_startup_select.sv
// clock source selection, start-up delay sequencing and trim registers
module clock_source_startup_select #(
    parameter logic [15:0] WD_TICKS_4P1MS = 16'(clk_startup_pkg::WD_4P1MS),
    parameter logic [15:0] WD_TICKS_4MS = 16'(clk_startup_pkg::WD_4MS),
    parameter logic [15:0] WD_TICKS_65MS = 16'(clk_startup_pkg::WD_65MS),
    parameter logic [15:0] WD_TICKS_64MS = 16'(clk_startup_pkg::WD_64MS),
    parameter logic [15:0] LF_WAKE_LONG_CK = clk_startup_pkg::CK_LF_WAKE_32K
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire clk_startup_pkg::fuse_t fuses,
    input wire logic [7:0] factory_trim_3v,
    input wire logic sleep_request,
    input wire logic oscillator_input_pin,
    input wire logic lf_crystal_clk,
    input wire logic rc_osc_clk,
    input wire logic osc_128k_clk,
    input wire logic watchdog_osc_clk,
    input wire clk_startup_pkg::avmm_req_t avmm_req,
    output clk_startup_pkg::avmm_rsp_t avmm_rsp,
    output logic system_clock_enable,
    output clk_startup_pkg::src_t source_select,
    output logic [7:0] rc_trim_register,
    output logic [3:0] prescaler_select_field
);
    import clk_startup_pkg::*;

    core_state_t s_r;
    core_state_t s_nxt;
    logic [NUM_CLK-1:0] pin_vec;
    logic [NUM_CLK-1:0] rise;
    logic src_edge;
    logic wd_tick;
    logic req;

    assign pin_vec[CLK_EXT] = oscillator_input_pin;
    assign pin_vec[CLK_RC] = rc_osc_clk;
    assign pin_vec[CLK_K128] = osc_128k_clk;
    assign pin_vec[CLK_LF] = lf_crystal_clk;
    assign pin_vec[CLK_WDOG] = watchdog_osc_clk;

    // every clock pin is foreign to core_clk, so each is synchronised
    for (genvar i = 0; i < NUM_CLK; i++) begin : g_sync
        clk_edge_sync u_sync (
            .core_clk(core_clk),
            .reset(reset),
            .async_in(pin_vec[i]),
            .rise(rise[i])
        );
    end

    // cycle counts run on the chosen source's own edges
    assign src_edge = rise[int'(s_r.src)];
    // ms delay is timed by the watchdog oscillator whatever the source
    assign wd_tick = rise[CLK_WDOG];
    assign req = avmm_req.read | avmm_req.write;

    function automatic src_t decode_src(input logic [3:0] sel);
        if (sel == SEL_EXT) begin
            decode_src = SRC_EXT;
        end else if (sel == SEL_K128) begin
            decode_src = SRC_K128;
        end else if (sel[3:1] == SEL_LF_HI || sel[3:1] == SEL_LF_LO) begin
            decode_src = SRC_LF;
        end else begin
            // unsupported codes fall back to the shipped RC choice
            decode_src = SRC_RC;
        end
    endfunction : decode_src

    function automatic logic sel_known(input logic [3:0] sel);
        sel_known = (sel == SEL_EXT) || (sel == SEL_RC) ||
            (sel == SEL_K128) || (sel[3:1] == SEL_LF_HI) ||
            (sel[3:1] == SEL_LF_LO);
    endfunction : sel_known

    function automatic logic [15:0] ms_target(input src_t src,
                                              input logic [1:0] startup_time_fuses,
                                              input logic rstdis);
        logic internal;
        internal = (src == SRC_RC) || (src == SRC_K128);
        case (startup_time_fuses)
            SUT_SHORT: begin
                // keeps a window to enter programming mode
                ms_target = (rstdis && internal) ? WD_TICKS_4P1MS
                                                 : 16'h0000;
            end
            SUT_MID: begin
                ms_target = (src == SRC_K128) ? WD_TICKS_4MS
                                              : WD_TICKS_4P1MS;
            end
            // reserved code is treated as the longest delay
            default: begin
                ms_target = (src == SRC_K128) ? WD_TICKS_64MS
                                              : WD_TICKS_65MS;
            end
        endcase
    endfunction : ms_target

    function automatic logic [15:0] wake_target(input src_t src,
                                                input logic sel0);
        if (src == SRC_LF) begin
            wake_target = sel0 ? LF_WAKE_LONG_CK : CK_LF_WAKE_1K;
        end else begin
            wake_target = CK_WAKE_SHORT;
        end
    endfunction : wake_target

    function automatic logic [31:0] read_mux(input logic [4:0] addr,
                                             input core_state_t s);
        logic [31:0] d;
        d = RDATA_UNMAPPED;
        case (addr)
            OFF_TRIM: d[7:0] = s.trim;
            OFF_PRESC: d[3:0] = s.presc;
            OFF_STATUS: begin
                d[STAT_RUN_BIT] = s.clk_en;
                d[STAT_SRC_LSB +: 2] = s.src;
                d[STAT_PHASE_LSB +: 3] = s.phase;
                d[STAT_BADSEL_BIT] = s.bad_sel;
                d[STAT_BADSUT_BIT] = s.bad_sut;
            end
            OFF_FUSE: begin
                d[FUSE_SEL_LSB +: 4] = s.fuse.sel;
                d[FUSE_SUT_LSB +: 2] = s.fuse.startup_time_fuses;
                d[FUSE_RSTDIS_BIT] = s.fuse.rstdis;
                d[FUSE_DIV8_BIT] = s.fuse.div8;
            end
            default: d = RDATA_UNMAPPED;
        endcase
        read_mux = d;
    endfunction : read_mux

    always_comb begin
        s_nxt = s_r;
        if (reset) begin
            // fuses are static; they are captured while reset is held
            s_nxt = '0;
            s_nxt.fuse = fuses;
            s_nxt.src = decode_src(fuses.sel);
            s_nxt.bad_sel = ~sel_known(fuses.sel);
            s_nxt.bad_sut = (fuses.startup_time_fuses == SUT_RSVD);
            s_nxt.phase = PH_MS;
            s_nxt.ms_tgt = ms_target(decode_src(fuses.sel), fuses.startup_time_fuses,
                                     fuses.rstdis);
            s_nxt.ck_tgt = (decode_src(fuses.sel) == SRC_LF) ? CK_LF_RESET
                                                 : CK_INT_RESET;
            s_nxt.trim = factory_trim_3v;
            s_nxt.presc = fuses.div8 ? PRESC_RESET_DIV8
                                     : PRESC_RESET_DIV1;
            s_nxt.waitreq = 1'b1;
        end else begin
            case (s_r.phase)
                PH_MS: begin
                    if (s_r.ms_cnt == s_r.ms_tgt) begin
                        s_nxt.phase = PH_CK;
                        s_nxt.ms_cnt = 16'h0000;
                    end else if (wd_tick) begin
                        s_nxt.ms_cnt = s_r.ms_cnt + 16'h0001;
                    end
                end
                PH_CK, PH_WAKE: begin
                    if (s_r.ck_cnt == s_r.ck_tgt) begin
                        s_nxt.phase = PH_RUN;
                        s_nxt.clk_en = 1'b1;
                        s_nxt.ck_cnt = 16'h0000;
                    end else if (src_edge) begin
                        s_nxt.ck_cnt = s_r.ck_cnt + 16'h0001;
                    end
                end
                PH_RUN: begin
                    if (sleep_request) begin
                        s_nxt.phase = PH_SLEEP;
                        s_nxt.clk_en = 1'b0;
                        s_nxt.ck_tgt = wake_target(s_r.src, s_r.fuse.sel[0]);
                    end
                end
                PH_SLEEP: begin
                    // the wake count starts only once sleep is withdrawn
                    if (!sleep_request) begin
                        s_nxt.phase = PH_WAKE;
                    end
                end
                default: s_nxt.phase = PH_MS;
            endcase

            // one wait cycle per access, then the answer
            s_nxt.waitreq = 1'b1;
            if (req && s_r.waitreq) begin
                s_nxt.waitreq = 1'b0;
                s_nxt.rdata = read_mux(avmm_req.address, s_r);
            end
            if (avmm_req.write && !s_r.waitreq) begin
                if (avmm_req.address == OFF_TRIM) begin
                    s_nxt.trim = avmm_req.writedata[7:0];
                end
                if (avmm_req.address == OFF_PRESC) begin
                    s_nxt.presc = avmm_req.writedata[3:0];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        s_r <= s_nxt;
    end

    assign avmm_rsp.readdata = s_r.rdata;
    assign avmm_rsp.waitrequest = s_r.waitreq;
    assign system_clock_enable = s_r.clk_en;
    assign source_select = s_r.src;
    assign rc_trim_register = s_r.trim;
    assign prescaler_select_field = s_r.presc;

    // helper: independent count of source edges in the counting phases
    logic [15:0] edge_h;
    always_ff @(posedge core_clk) begin
        if (reset || !(s_r.phase == PH_CK || s_r.phase == PH_WAKE)) begin
            edge_h <= 16'h0000;
        end else if (src_edge && s_r.ck_cnt != s_r.ck_tgt) begin
            edge_h <= edge_h + 16'h0001;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    trim_load_a: assert property (
        $fell(reset) |-> rc_trim_register == $past(factory_trim_3v))
        else $error("trim not loaded from factory value at reset");

    presc_reset_a: assert property (
        $fell(reset) |-> prescaler_select_field ==
            ($past(fuses.div8) ? PRESC_RESET_DIV8 : PRESC_RESET_DIV1))
        else $error("prescaler reset value wrong");

    lf_select_a: assert property (
        s_r.fuse.sel[3:1] == SEL_LF_HI |-> source_select == SRC_LF)
        else $error("crystal code did not select crystal");

    rc_select_a: assert property (
        s_r.fuse.sel == SEL_RC |-> source_select == SRC_RC)
        else $error("RC code did not select RC");

    k128_select_a: assert property (
        s_r.fuse.sel == SEL_K128 |-> source_select == SRC_K128)
        else $error("128k code did not select 128k oscillator");

    ext_select_a: assert property (
        s_r.fuse.sel == SEL_EXT |-> source_select == SRC_EXT)
        else $error("external code did not select external clock");

    rstdis_delay_a: assert property (
        $fell(reset) && $past(fuses.rstdis) &&
        $past(fuses.startup_time_fuses) == SUT_SHORT &&
        (s_r.src == SRC_RC || s_r.src == SRC_K128)
        |-> s_r.ms_tgt == WD_TICKS_4P1MS)
        else $error("reset pin disable did not lengthen delay");

    reset_edges_a: assert property (
        $rose(system_clock_enable) && $past(s_r.phase) == PH_CK
        |-> edge_h == ((s_r.src == SRC_LF) ? CK_LF_RESET : CK_INT_RESET))
        else $error("wrong source cycle count before release");

    wake_edges_a: assert property (
        $rose(system_clock_enable) && $past(s_r.phase) == PH_WAKE
        |-> edge_h == ((s_r.src != SRC_LF) ? CK_WAKE_SHORT :
            (s_r.fuse.sel[0] ? LF_WAKE_LONG_CK : CK_LF_WAKE_1K)))
        else $error("wrong wake-up cycle count");

    ms_wdog_a: assert property (
        s_r.phase == PH_MS && !wd_tick && s_r.ms_cnt != s_r.ms_tgt
        |=> s_r.ms_cnt == $past(s_r.ms_cnt) && !system_clock_enable)
        else $error("ms delay advanced without a watchdog tick");

    bus_ack_a: assert property (
        !avmm_rsp.waitrequest |=> avmm_rsp.waitrequest)
        else $error("waitrequest low for more than one cycle");

endmodule : clock_source_startup_select

//--- clock_source_driver.sv
// far-side model: enable-gated source and watchdog oscillator pins
module clock_source_driver #(
    parameter int HALF = 5
) (
    input wire logic core_clk,
    input wire logic [4:0] en,
    output logic [4:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    int tick = 0;
    initial pins = 5'h00;
    // fixed period, so no cycle-to-cycle step ever exceeds 2%
    // a pin finishes its high phase when disabled, then rests low
    // frequency never changes at all, so no reset hold is needed
    always @(posedge core_clk) begin
        if (tick == HALF - 1) begin
            tick <= 0;
            pins <= pins ^ (en | pins);
        end else begin
            tick <= tick + 1;
        end
    end
endmodule : clock_source_driver

//--- clock_source_startup_select_bench.sv
// self-checking bench for clock source start-up selection
module clock_source_startup_select_bench;
    import clk_startup_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 5;
    localparam int LIMIT = 80000;
    logic core_clk;
    logic reset;
    fuse_t fuses;
    logic [7:0] factory_trim_3v;
    logic sleep_request;
    logic [4:0] en;
    logic [4:0] pins;
    avmm_req_t avmm_req;
    avmm_rsp_t avmm_rsp;
    logic system_clock_enable;
    src_t source_select;
    logic [7:0] rc_trim_register;
    logic [3:0] prescaler_select_field;
    logic [31:0] rd;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int test_no = 0;

    clock_source_driver #(.HALF(HALF)) partner (
        .core_clk(core_clk), .en(en), .pins(pins));

    clock_source_startup_select #(
        .WD_TICKS_4P1MS(16'h0005), .WD_TICKS_4MS(16'h0004),
        .WD_TICKS_65MS(16'h0009), .WD_TICKS_64MS(16'h0008),
        .LF_WAKE_LONG_CK(16'h0028)
    ) dut (
        .core_clk(core_clk), .reset(reset), .fuses(fuses),
        .factory_trim_3v(factory_trim_3v), .sleep_request(sleep_request),
        .oscillator_input_pin(pins[CLK_EXT]), .lf_crystal_clk(pins[CLK_LF]),
        .rc_osc_clk(pins[CLK_RC]), .osc_128k_clk(pins[CLK_K128]),
        .watchdog_osc_clk(pins[CLK_WDOG]), .avmm_req(avmm_req),
        .avmm_rsp(avmm_rsp), .system_clock_enable(system_clock_enable),
        .source_select(source_select), .rc_trim_register(rc_trim_register),
        .prescaler_select_field(prescaler_select_field));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check_val

    // one Avalon-MM access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] wd, output logic [31:0] data);
        // only the bench-wide cycle limit ends a hung wait
        avmm_req <= '{address: a, read: !wr, write: wr, writedata: wd};
        do begin
            @(posedge core_clk);
        end while (avmm_rsp.waitrequest !== 1'b0);
        data = avmm_rsp.readdata;
        avmm_req <= '0;
        @(posedge core_clk);
    endtask : bus

    // let exactly k rising edges through on one pin, then settle
    task automatic pulse(input int idx, input int k);
        int seen;
        int guard;
        logic last;
        seen = 0;
        guard = 0;
        last = pins[idx];
        if (k > 0) begin
            en[idx] <= 1'b1;
            while (seen < k && guard < 40000) begin
                @(posedge core_clk);
                guard++;
                if (pins[idx] && !last) seen++;
                last = pins[idx];
            end
            en[idx] <= 1'b0;
            repeat (2 * HALF + 2) @(posedge core_clk);
        end
    endtask : pulse

    // reset with fuses f, walk the start-up and one sleep/wake round
    task automatic run_cfg(input fuse_t f, input int src, input src_t ss,
                           input int t, input int n, input int w);
        en <= 5'h00;
        fuses <= f;
        reset <= 1'b1;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
        check_val(source_select, ss);
        check_val(rc_trim_register, factory_trim_3v);
        check_val(prescaler_select_field, f.div8 ? 4'h3 : 4'h0);
        if (t > 0) begin
            pulse(CLK_WDOG, t - 1);
            pulse(src, n + 2);
            check_val(system_clock_enable, 1'b0);
            pulse(CLK_WDOG, 1);
        end
        pulse(src, n - 1);
        check_val(system_clock_enable, 1'b0);
        pulse(src, 1);
        check_val(system_clock_enable, 1'b1);
        sleep_request <= 1'b1;
        repeat (3) @(posedge core_clk);
        check_val(system_clock_enable, 1'b0);
        sleep_request <= 1'b0;
        repeat (2) @(posedge core_clk);
        pulse(src, w - 1);
        check_val(system_clock_enable, 1'b0);
        pulse(src, 1);
        check_val(system_clock_enable, 1'b1);
        test_no++;
        $display("test %0d done", test_no);
    endtask : run_cfg

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        reset = 1'b1;
        fuses = '0;
        factory_trim_3v = 8'h5a;
        sleep_request = 1'b0;
        avmm_req = '0;
        en = 5'h00;
        run_cfg('{4'h2, 2'h1, 1'b0, 1'b1}, CLK_RC, SRC_RC, 5, 14, 6);
        // register access after start-up
        bus(1'b0, OFF_TRIM, 32'h0000_0000, rd);
        check_val(rd, 32'h0000_005a);
        bus(1'b1, OFF_TRIM, 32'h0000_00a7, rd);
        check_val(rc_trim_register, 8'ha7);
        bus(1'b0, OFF_TRIM, 32'h0000_0000, rd);
        check_val(rd, 32'h0000_00a7);
        bus(1'b0, OFF_PRESC, 32'h0000_0000, rd);
        check_val(rd, 32'h0000_0003);
        bus(1'b1, OFF_PRESC, 32'h0000_0005, rd);
        check_val(prescaler_select_field, 4'h5);
        bus(1'b1, OFF_FUSE, 32'h0000_00ff, rd);
        bus(1'b0, OFF_FUSE, 32'h0000_0000, rd);
        check_val(rd, 32'h0000_0092);
        bus(1'b0, 5'h10, 32'h0000_0000, rd);
        check_val(rd, 32'h0000_0000);
        bus(1'b0, OFF_STATUS, 32'h0000_0000, rd);
        check_val(rd, 32'h0000_0013);
        $display("test registers done");
        run_cfg('{4'h2, 2'h0, 1'b1, 1'b0}, CLK_RC, SRC_RC, 5, 14, 6);
        run_cfg('{4'h3, 2'h1, 1'b0, 1'b0}, CLK_K128, SRC_K128, 4, 14, 6);
        run_cfg('{4'h3, 2'h2, 1'b0, 1'b1}, CLK_K128, SRC_K128, 8, 14, 6);
        run_cfg('{4'h0, 2'h0, 1'b0, 1'b0}, CLK_EXT, SRC_EXT, 0, 14, 6);
        run_cfg('{4'h0, 2'h2, 1'b0, 1'b0}, CLK_EXT, SRC_EXT, 9, 14, 6);
        run_cfg('{4'h6, 2'h2, 1'b0, 1'b0}, CLK_LF, SRC_LF, 9, 4, 1024);
        run_cfg('{4'h7, 2'h1, 1'b0, 1'b1}, CLK_LF, SRC_LF, 5, 4, 40);
        run_cfg('{4'h5, 2'h0, 1'b0, 1'b0}, CLK_LF, SRC_LF, 0, 4, 40);
        // unsupported select and reserved start-up code
        run_cfg('{4'h1, 2'h3, 1'b0, 1'b0}, CLK_RC, SRC_RC, 9, 14, 6);
        bus(1'b0, OFF_STATUS, 32'h0000_0000, rd);
        check_val(rd, 32'h0000_00d3);
        complete_run();
    end
endmodule : clock_source_startup_select_bench
